/* File: bsx_pkg.sv */
// Constants and carrier types shared by the boundary-scan emulator core
package bsx_pkg;

   // ****************************************
   // Register sizes
   // ****************************************
   localparam int DR_LEN = 8;
   localparam int IR_LEN = 2;
   localparam int STATUS_LEN = 2;
   localparam int IR_SR_LEN = IR_LEN + STATUS_LEN;

   // ****************************************
   // Instruction codes and reset values
   // ****************************************
   localparam logic [IR_LEN-1:0] IR_EXTEST = 2'h0;
   localparam logic [IR_LEN-1:0] IR_DUMMY = 2'h1;
   localparam logic [IR_LEN-1:0] IR_BYPASS = 2'h3;
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 2'h1;
   localparam logic [IR_LEN-1:0] IR_HOLD_N_RST = 2'h0;
   // Configuration code shifted out as status; value is arbitrary
   localparam logic [STATUS_LEN-1:0] CFG_CODE = 2'h2;
   // Cells whose bit is set read back their own drive at capture
   localparam logic [DR_LEN-1:0] PIN_OUT_MASK = 8'hF0;
   localparam logic [DR_LEN-1:0] DR_RST = 8'h00;

   // ****************************************
   // Timing of the test clock against the core clock
   // ****************************************
   localparam int CORE_PERIOD_NS = 100;
   localparam int TCK_PERIOD_NS = 800;
   localparam int CORE_PER_TCK = TCK_PERIOD_NS / CORE_PERIOD_NS;

   // ****************************************
   // One-hot state carriers
   // ****************************************
   typedef struct packed {
      logic logic_reset_state;
      logic run_idle_state_n;
      logic sel_data_state;
      logic sel_instr_state;
   } bsx_first_t;

   typedef struct packed {
      logic capture_state;
      logic shift_state;
      logic exit_one_state;
      logic pause_state;
      logic exit_two_state;
      logic update_state;
   } bsx_second_t;

endpackage

/* File: bsx_word_buf.sv */
// Two-entry buffer for updated test words, all outputs registered
`timescale 1ns/1ps
module bsx_word_buf (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   input wire logic [bsx_pkg::DR_LEN-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [bsx_pkg::DR_LEN-1:0] out_data_out,
   input wire logic out_ready_in
);

   logic [bsx_pkg::DR_LEN-1:0] head, spare, next_head, next_spare;
   logic head_v, spare_v, next_head_v, next_spare_v;
   logic push, pop;

   // Spare slot absorbs one word while the receiver stalls
   assign push = in_valid_in & ~spare_v;
   assign pop = head_v & out_ready_in;

   // Next contents of head and spare
   always_comb begin
      next_head = head;
      next_spare = spare;
      next_head_v = head_v;
      next_spare_v = spare_v;
      if (pop) begin
         if (spare_v) begin
            next_head = spare;
            next_spare_v = 1'b0;
         end else begin
            next_head = in_data_in;
            next_head_v = push;
         end
      end else if (push) begin
         if (!head_v) begin
            next_head = in_data_in;
            next_head_v = 1'b1;
         end else begin
            next_spare = in_data_in;
            next_spare_v = 1'b1;
         end
      end
   end

   // Storage
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         head <= bsx_pkg::DR_RST;
         spare <= bsx_pkg::DR_RST;
         head_v <= 1'b0;
         spare_v <= 1'b0;
      end else begin
         head <= next_head;
         spare <= next_spare;
         head_v <= next_head_v;
         spare_v <= next_spare_v;
      end
   end

   assign in_ready_out = ~spare_v;
   assign out_valid_out = head_v;
   assign out_data_out = head;

endmodule

/* File: bsx_scan_core.sv */
// Boundary-scan emulator core: test port controller, instruction and data paths
`timescale 1ns/1ps
module bsx_scan_core (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   input wire logic [bsx_pkg::DR_LEN-1:0] pad_in,
   output logic [bsx_pkg::DR_LEN-1:0] pin_drive_out,
   output logic update_strobe_out,
   output logic word_valid_out,
   output logic [bsx_pkg::DR_LEN-1:0] word_data_out,
   input wire logic word_ready_in
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic tck_s1, tck_s2, tck_d;
   logic tms_s1, tms_s2, tdi_s1, tdi_s2;
   logic [bsx_pkg::DR_LEN-1:0] pad_s1, pad_s2;
   logic tck_rise, tck_fall;

   // Three test pins and the pad bus
   // Two flops on every pin; a third tck flop finds the edges
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_d <= 1'b0;
         tms_s1 <= 1'b1;
         tms_s2 <= 1'b1;
         tdi_s1 <= 1'b1;
         tdi_s2 <= 1'b1;
         pad_s1 <= bsx_pkg::DR_RST;
         pad_s2 <= bsx_pkg::DR_RST;
      end else begin
         tck_s1 <= tck_in;
         tck_s2 <= tck_s1;
         tck_d <= tck_s2;
         tms_s1 <= tms_in;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi_in;
         tdi_s2 <= tdi_s1;
         pad_s1 <= pad_in;
         pad_s2 <= pad_s1;
      end
   end

   assign tck_rise = tck_s2 & ~tck_d;
   assign tck_fall = ~tck_s2 & tck_d;

   // ****************************************
   // Test port controller
   // ****************************************
   bsx_pkg::bsx_first_t first, next_first;
   bsx_pkg::bsx_second_t second, next_second;
   logic run2, busy2, idle_st;

   // Second machine busy before update; first machine enable is its inverse
   assign run2 = second.capture_state | second.shift_state | second.exit_one_state
      | second.pause_state | second.exit_two_state;
   assign busy2 = run2 | second.update_state;
   // Idle read back from inverted flop
   assign idle_st = ~first.run_idle_state_n;

   // Next state of both linked machines
   always_comb begin
      next_first = first;
      next_second = second;
      if (tck_rise) begin
         next_second.capture_state = ~tms_s2 & (first.sel_data_state | first.sel_instr_state)
            & ~busy2;
         next_second.shift_state = ~tms_s2 & (second.capture_state | second.exit_two_state
            | second.shift_state);
         next_second.exit_one_state = tms_s2 & (second.capture_state | second.shift_state);
         next_second.pause_state = ~tms_s2 & (second.exit_one_state | second.pause_state);
         next_second.exit_two_state = tms_s2 & second.pause_state;
         next_second.update_state = tms_s2 & (second.exit_one_state | second.exit_two_state);
         if (!run2) begin
            next_first.logic_reset_state = tms_s2 & (first.logic_reset_state
               | (first.sel_instr_state & ~second.update_state));
            next_first.run_idle_state_n = ~(~tms_s2 & (first.logic_reset_state | idle_st
               | second.update_state));
            next_first.sel_data_state = (tms_s2 & (idle_st | second.update_state))
               | (~tms_s2 & first.sel_data_state & ~second.update_state);
            next_first.sel_instr_state = ~second.update_state & ((tms_s2 & first.sel_data_state)
               | (~tms_s2 & first.sel_instr_state));
         end
      end
   end

   // Global reset gives the power-up state; all flops clear
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         first <= '0;
         second <= '0;
      end else begin
         first <= next_first;
         second <= next_second;
      end
   end

   // ****************************************
   // Instruction, bypass and test data shifters
   // ****************************************
   logic [bsx_pkg::IR_SR_LEN-1:0] ir_shift, next_ir_shift;
   logic [bsx_pkg::IR_LEN-1:0] ir_hold_n, next_ir_hold_n, ir_code;
   logic byp, next_byp;
   logic [bsx_pkg::DR_LEN-1:0] dr_shift, next_dr_shift, dr_capture;
   logic tdr_mode;

   assign ir_code = ~ir_hold_n;
   // Dummy code behaves as the external test
   assign tdr_mode = (ir_code == bsx_pkg::IR_EXTEST) | (ir_code == bsx_pkg::IR_DUMMY);

   // Output cells read back drive, input cells read pad
   assign dr_capture = (bsx_pkg::PIN_OUT_MASK & pin_drive_out)
      | (~bsx_pkg::PIN_OUT_MASK & pad_s2);

   // Next values of the shifters and the instruction holding register
   always_comb begin
      next_ir_shift = ir_shift;
      next_ir_hold_n = ir_hold_n;
      next_byp = byp;
      next_dr_shift = dr_shift;
      if (tck_rise) begin
         if (first.sel_instr_state) begin
            if (second.capture_state) begin
               next_ir_shift = {bsx_pkg::CFG_CODE, bsx_pkg::IR_CAPTURE};
            end else if (second.shift_state) begin
               next_ir_shift = {tdi_s2, ir_shift[bsx_pkg::IR_SR_LEN-1:1]};
            end
         end
         if (first.sel_data_state && !tdr_mode) begin
            if (second.capture_state) begin
               next_byp = 1'b0;
            end else if (second.shift_state) begin
               next_byp = tdi_s2;
            end
         end
         if (first.sel_data_state && tdr_mode) begin
            if (second.capture_state) begin
               next_dr_shift = dr_capture;
            end else if (second.shift_state) begin
               next_dr_shift = {tdi_s2, dr_shift[bsx_pkg::DR_LEN-1:1]};
            end
         end
         // Clear in logic reset, load in update
         if (first.logic_reset_state) begin
            next_ir_hold_n = bsx_pkg::IR_HOLD_N_RST;
         end else if (first.sel_instr_state && second.update_state) begin
            next_ir_hold_n = ~ir_shift[bsx_pkg::IR_LEN-1:0];
         end
      end
   end

   // Shifter storage
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ir_shift <= '0;
         ir_hold_n <= bsx_pkg::IR_HOLD_N_RST;
         byp <= 1'b0;
         dr_shift <= bsx_pkg::DR_RST;
      end else begin
         ir_shift <= next_ir_shift;
         ir_hold_n <= next_ir_hold_n;
         byp <= next_byp;
         dr_shift <= next_dr_shift;
      end
   end

   // ****************************************
   // Falling-edge outputs and update path
   // ****************************************
   logic next_tdo, next_tdo_oe, next_update_strobe, serial_bit, update_event;
   logic [bsx_pkg::DR_LEN-1:0] next_pin_drive;
   logic word_pend, next_word_pend, buf_ready;

   assign serial_bit = first.sel_instr_state ? ir_shift[0] : (tdr_mode ? dr_shift[0] : byp);
   assign update_event = tck_fall & second.update_state & first.sel_data_state & tdr_mode;

   // Next values of the falling-edge registers
   always_comb begin
      next_tdo = tdo_out;
      next_tdo_oe = tdo_oe_out;
      next_update_strobe = update_strobe_out;
      next_pin_drive = pin_drive_out;
      if (tck_fall) begin
         // Changes on falling edge, driven only in shift
         next_tdo = serial_bit;
         next_tdo_oe = second.shift_state;
         // Strobe spans one test clock period
         next_update_strobe = second.update_state & first.sel_data_state;
      end
      if (update_event) begin
         next_pin_drive = dr_shift;
      end
      // A new word wins over a push in the same cycle
      next_word_pend = (word_pend & ~buf_ready) | update_event;
   end

   // Falling-edge register storage
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
         update_strobe_out <= 1'b0;
         pin_drive_out <= bsx_pkg::DR_RST;
         word_pend <= 1'b0;
      end else begin
         tdo_out <= next_tdo;
         tdo_oe_out <= next_tdo_oe;
         update_strobe_out <= next_update_strobe;
         pin_drive_out <= next_pin_drive;
         word_pend <= next_word_pend;
      end
   end

   // Test clock cannot stall, so a word waits in word_pend until the buffer frees
   bsx_word_buf u_word_buf (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(word_pend),
      .in_data_in(pin_drive_out),
      .in_ready_out(buf_ready),
      .out_valid_out(word_valid_out),
      .out_data_out(word_data_out),
      .out_ready_in(word_ready_in)
   );

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   property p_first_onehot;
      $onehot({first.logic_reset_state, idle_st, first.sel_data_state,
         first.sel_instr_state});
   endproperty
   a_first_onehot: assert property (p_first_onehot)
      else $error("first machine not one-hot");

   property p_second_onehot;
      $onehot0(second) && (!busy2 || first.sel_data_state || first.sel_instr_state);
   endproperty
   a_second_onehot: assert property (p_second_onehot)
      else $error("second machine bad or unqualified");

   property p_first_holds;
      run2 |=> $stable(first);
   endproperty
   a_first_holds: assert property (p_first_holds)
      else $error("first machine moved while second ran");

   property p_update_exit;
      tck_rise && second.update_state |=> !busy2
         && (tms_s2 ? first.sel_data_state : idle_st);
   endproperty
   a_update_exit: assert property (p_update_exit)
      else $error("wrong state after update");

   property p_ir_capture;
      tck_rise && second.capture_state && first.sel_instr_state
         |=> ir_shift == {bsx_pkg::CFG_CODE, bsx_pkg::IR_CAPTURE};
   endproperty
   a_ir_capture: assert property (p_ir_capture)
      else $error("instruction capture value wrong");

   property p_ir_reset;
      tck_rise && first.logic_reset_state |=> ir_code == bsx_pkg::IR_BYPASS;
   endproperty
   a_ir_reset: assert property (p_ir_reset)
      else $error("instruction not bypass in logic reset");

   property p_byp_capture;
      tck_rise && second.capture_state && first.sel_data_state && !tdr_mode |=> !byp;
   endproperty
   a_byp_capture: assert property (p_byp_capture)
      else $error("bypass did not capture zero");

   property p_tdo_enable;
      tck_fall |=> tdo_oe_out == $past(second.shift_state);
   endproperty
   a_tdo_enable: assert property (p_tdo_enable)
      else $error("serial out enable wrong");

   property p_update_strobe;
      update_event |=> update_strobe_out && pin_drive_out == $past(dr_shift) && word_pend;
   endproperty
   a_update_strobe: assert property (p_update_strobe)
      else $error("update strobe or transfer missing");

   // Driven pins move only on a data update, never while shifting
   property p_pins_hold;
      !update_event |=> $stable(pin_drive_out);
   endproperty
   a_pins_hold: assert property (p_pins_hold)
      else $error("pin drive changed outside update");

   property p_ir_hold_stable;
      !(tck_rise && (first.logic_reset_state || (first.sel_instr_state && second.update_state)))
         |=> $stable(ir_hold_n);
   endproperty
   a_ir_hold_stable: assert property (p_ir_hold_stable)
      else $error("instruction changed outside update or reset");

   property p_byp_hold;
      !(tck_rise && first.sel_data_state && !tdr_mode) |=> $stable(byp);
   endproperty
   a_byp_hold: assert property (p_byp_hold)
      else $error("bypass bit moved outside data path");

   property p_dr_capture;
      tck_rise && second.capture_state && first.sel_data_state && tdr_mode
         |=> dr_shift == $past(dr_capture);
   endproperty
   a_dr_capture: assert property (p_dr_capture)
      else $error("test register capture wrong");

   c_shift_dr: cover property (second.shift_state && first.sel_data_state && tdr_mode);
   c_update_ir: cover property (second.update_state && first.sel_instr_state);
   c_logic_reset: cover property (first.logic_reset_state);
   c_buf_stall: cover property (word_pend && !buf_ready);

endmodule

/* File: bsx_tap_host.sv */
// Behavioural test controller that drives three test port pins and reads serial out
`timescale 1ns/1ps
module bsx_tap_host (
   input wire logic core_clk_in,
   input wire logic tdo_in,
   input wire logic tdo_oe_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   // ****************************************
   // Pin drive
   // ****************************************
   // Idle lines sit at their pulled-up level; the test clock stands still between frames
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end

   // Set while clock low
   // One test clock of eight core cycles; serial out is read just before the next fall,
   // so the device's slow synchronised response has settled
   task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
      @(posedge core_clk_in);
      tck_out <= 1'b0;
      tms_out <= tms;
      tdi_out <= tdi;
      repeat (4) @(posedge core_clk_in);
      tck_out <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      // A released serial line reads inverted, so a missing enable corrupts the data
      tdo = tdo_oe_in ? tdo_in : ~tdo_in;
      oe = tdo_oe_in;
   endtask

   // Frame over: clock parked low, mode and data back at pull-up level
   task automatic release_lines();
      @(posedge core_clk_in);
      tck_out <= 1'b0;
      tms_out <= 1'b1;
      tdi_out <= 1'b1;
   endtask
endmodule

/* File: boundary_scan_extest_emulator_tb.sv */
// Self-checking bench for the boundary-scan emulator core
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module boundary_scan_extest_emulator_tb;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic tck, tms, tdi, tdo, tdo_oe, update_strobe, word_valid, word_ready = 1'b0;
   logic [7:0] pad = 8'h3C;
   logic [7:0] pin_drive, word_data;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   // ****************************************
   // Clock, instances, watchdog
   // ****************************************
   initial begin
      forever #50 core_clk_in = ~core_clk_in;
   end

   bsx_scan_core uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck),
      .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .pad_in(pad),
      .pin_drive_out(pin_drive), .update_strobe_out(update_strobe), .word_valid_out(word_valid),
      .word_data_out(word_data), .word_ready_in(word_ready));

   bsx_tap_host host (.core_clk_in(core_clk_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe),
      .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

   // Ceiling well above the roughly 1300 cycles the tests need
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         summarize();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   // Idle, select, capture, n shifts, optional pause, update, idle
   task automatic scan(input logic ir, input int n, input logic [15:0] din,
                       input logic pause, output logic [15:0] dout);
      logic t, oe;
      dout = '0;
      host.tick(1'b1, 1'b1, t, oe);
      if (ir) host.tick(1'b1, 1'b1, t, oe);
      host.tick(1'b0, 1'b1, t, oe);
      host.tick(1'b0, 1'b1, t, oe);
      for (int i = 0; i < n; i++) begin
         host.tick(logic'(i == n - 1), din[i], t, oe);
         dout[i] = t;
         `CHK(oe, 1'b1)
      end
      if (pause) begin
         host.tick(1'b0, 1'b1, t, oe);
         host.tick(1'b0, 1'b1, t, oe);
         host.tick(1'b1, 1'b1, t, oe);
      end
      host.tick(1'b1, 1'b1, t, oe);
      host.tick(1'b0, 1'b1, t, oe);
      `CHK(oe, 1'b0)
      @(negedge core_clk_in);
   endtask

   // Waits a bounded time for the buffer head, checks it, then pops it
   task automatic pop(input logic [7:0] exp);
      int k;
      k = 0;
      do begin
         @(posedge core_clk_in);
         k++;
      end while (word_valid !== 1'b1 && k < 60);
      `CHK(word_valid, 1'b1)
      `CHK(word_data, exp)
      word_ready <= 1'b1;
      @(posedge core_clk_in);
      word_ready <= 1'b0;
   endtask

   task automatic done(input string name);
      host.release_lines();
      $display("test %s done", name);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Power-up: idle controller with bypass selected, so a 4-bit scan lags one bit
   task automatic t_reset();
      logic [15:0] d;
      `CHK({tdo, tdo_oe, update_strobe, word_valid, pin_drive}, 12'h000)
      scan(1'b0, 4, 16'h000B, 1'b0, d);
      `CHK(d[3:0], 4'h6)
      `CHK(pin_drive, bsx_pkg::DR_RST)
      done("reset");
   endtask

   // Every instruction code, with capture and update of the data path behind it
   task automatic t_codes();
      logic [15:0] d;
      logic [7:0] w, drv;
      logic [1:0] c;
      logic t, oe;
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         scan(1'b1, 4, {12'h000, 2'h3, c}, 1'b0, d);
         `CHK(d[3:0], {bsx_pkg::CFG_CODE, bsx_pkg::IR_CAPTURE})
         w = 8'h5A ^ {c, c, c, c};
         drv = pin_drive;
         scan(1'b0, 8, {8'h00, w}, logic'(c == 2'h1), d);
         `CHK(update_strobe, 1'b1)
         if (c[1] == 1'b0) begin
            `CHK(d[7:0], (drv & bsx_pkg::PIN_OUT_MASK) | (pad & ~bsx_pkg::PIN_OUT_MASK))
            `CHK(pin_drive, w)
            pop(w);
         end else begin
            `CHK(d[7:0], {w[6:0], 1'b0})
            `CHK(pin_drive, drv)
            `CHK(word_valid, 1'b0)
         end
         host.tick(1'b0, 1'b1, t, oe);
         @(negedge core_clk_in);
         `CHK(update_strobe, 1'b0)
      end
      done("codes");
   endtask

   // Receiver stalls across two updates; both words come out in order
   task automatic t_stall();
      logic [15:0] d;
      scan(1'b1, 4, 16'h0000, 1'b0, d);
      scan(1'b0, 8, 16'h0081, 1'b0, d);
      scan(1'b0, 8, 16'h0042, 1'b0, d);
      `CHK(word_valid, 1'b1)
      pop(8'h81);
      pop(8'h42);
      @(negedge core_clk_in);
      `CHK(word_valid, 1'b0)
      done("stall");
   endtask

   // Five mode-select ones reach logic reset, which brings bypass back
   task automatic t_logic_reset();
      logic [15:0] d;
      logic t, oe;
      repeat (5) host.tick(1'b1, 1'b1, t, oe);
      host.tick(1'b0, 1'b1, t, oe);
      scan(1'b0, 4, 16'h000B, 1'b0, d);
      `CHK(d[3:0], 4'h6)
      `CHK(pin_drive, 8'h42)
      done("logic_reset");
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      @(negedge core_clk_in);
      t_reset();
      t_codes();
      t_stall();
      t_logic_reset();
      summarize();
   end
endmodule
